// *** csc_config_regs.sv ***
// Configuration register bank: keyboard, cache, management segments, stop clock and speed.
// Assumes a single-cycle register port on clk; pins arrive asynchronously and are synchronised here.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module csc_config_regs #(
   parameter int unsigned CYC_MS0 = csc_pkg::CYC_MS0,
   parameter int unsigned CYC_MS1 = csc_pkg::CYC_MS1,
   parameter int unsigned CYC_MS2 = csc_pkg::CYC_MS2
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // Straps and pins
   input  wire logic        kbd_strap_a_n,
   input  wire logic        kbd_strap_b_n,
   input  wire logic        speed_pin,
   input  wire logic        clock_halt_grant_n,
   // Same-domain inputs
   input  wire logic        sw_speed_bit,
   input  wire logic        halt_trigger,
   // Keyboard and dirty controls
   output logic             kbd_enable,
   output logic             kbd_color_sel,
   output logic             kbd_mouse_swap,
   output logic             dirty_check_en,
   output logic             dirty_status,
   // Cache controls
   output logic             page_mode_off,
   output logic             write_back_en,
   output logic      [2:0]  cache_size,
   output logic      [25:0] cache_limit,
   output logic             single_tag,
   output logic             cache_all,
   output logic             range_valid,
   // Management segments and DMA
   output logic             seg_3000_en,
   output logic             seg_6000_en,
   output logic             seg_f000_en,
   output logic             mgmt_proc_en,
   output logic             dma_local_bus_en,
   // Speed and stop clock
   output logic             alt_deturbo_en,
   output logic             turbo,
   output logic             halt_busy,
   output logic             clock_halt_request_n
);
   typedef struct packed {
      logic [7:0]  kbd;
      logic [7:0]  cache;
      logic [7:0]  seg;
      logic [7:0]  stop;
      logic [7:0]  rdata;
      logic [2:0]  boot;
      logic        page_off;
      logic [2:0]  size;
      logic [25:0] limit;
      logic        single;
      logic        all;
      logic        valid;
      logic        proc_en;
      logic        turbo;
   } csc_regs_t;

   typedef struct packed {
      logic        valid;
      logic        single;
      logic        all;
      logic [25:0] limit;
   } csc_range_t;

   csc_regs_t st_q, st_d;
   logic [2:0] pins_s;
   logic       strap_en;
   logic       grant_s;
   logic       speed_s;
   logic       req_n;

   csc_seq_if sq ();

   csc_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .pin    ({speed_pin, ~clock_halt_grant_n, kbd_strap_a_n & kbd_strap_b_n}),
      .level  (pins_s)
   );

   assign strap_en = pins_s[0];
   assign grant_s  = pins_s[1];
   assign speed_s  = pins_s[2];

   // Size decode: any code with the top bit set is the largest cache.
   function automatic logic [2:0] size_code(input logic [2:0] f);
      if (f[2]) begin
         return 3'(csc_pkg::CSC_SZ_512K);
      end
      return 3'(f);
   endfunction

   // Cacheable range decode; codes not listed for a size report invalid.
   function automatic csc_range_t range_decode(input logic [2:0] sz, input logic [2:0] r);
      csc_range_t o;
      o = '0;
      o.valid  = 1'b1;
      o.single = (r == 3'h0);
      unique case (sz)
         3'(csc_pkg::CSC_SZ_32K): begin
            unique case (r)
               3'h0:    o.limit = 26'h03FFFFF;
               3'h1:    o.limit = 26'h007FFFF;
               3'h3:    o.limit = 26'h0FFFFFF;
               3'h7:    o.limit = 26'h1FFFFFF;
               default: o.valid = 1'b0;
            endcase
         end
         3'(csc_pkg::CSC_SZ_64K): begin
            unique case (r)
               3'h0:    o.limit = 26'h07FFFFF;
               3'h1:    o.limit = 26'h0FFFFFF;
               3'h3:    o.limit = 26'h1FFFFFF;
               3'h7:    o.limit = 26'h3FFFFFF;
               default: o.valid = 1'b0;
            endcase
         end
         3'(csc_pkg::CSC_SZ_128K): begin
            unique case (r)
               3'h0:    o.limit = 26'h0FFFFFF;
               3'h1:    o.limit = 26'h1FFFFFF;
               3'h3:    o.limit = 26'h3FFFFFF;
               default: o.valid = 1'b0;
            endcase
         end
         3'(csc_pkg::CSC_SZ_256K): begin
            unique case (r)
               3'h0:    o.limit = 26'h1FFFFFF;
               3'h1:    o.limit = 26'h3FFFFFF;
               default: o.valid = 1'b0;
            endcase
         end
         default: begin
            if (r == 3'h0) begin
               o.all   = 1'b1;
               o.limit = 26'h3FFFFFF;
            end else begin
               o.valid = 1'b0;
            end
         end
      endcase
      if (!o.valid) begin
         o.single = 1'b0;
         o.limit  = '0;
      end
      return o;
   endfunction

   csc_range_t rng;

   always_comb begin
      st_d = st_q;
      rng  = '0;
      // The strap is taken once the synchroniser has settled; a software write wins.
      if (st_q.boot != csc_pkg::BOOT_CYCLES) begin
         st_d.boot = st_q.boot + 3'h1;
         if (st_q.boot == csc_pkg::BOOT_CYCLES - 3'h1) begin
            st_d.kbd[csc_pkg::KBD_ENABLE] = strap_en;
         end
      end
      if (wr) begin
         unique case (addr)
            csc_pkg::OFF_KBD: begin
               st_d.kbd  = wdata & csc_pkg::MASK_KBD;
               st_d.boot = csc_pkg::BOOT_CYCLES;
            end
            csc_pkg::OFF_CACHE: st_d.cache = wdata;
            csc_pkg::OFF_SEG:   st_d.seg   = wdata & csc_pkg::MASK_SEG;
            csc_pkg::OFF_STOP:  st_d.stop  = wdata;
            default: ;
         endcase
      end
      // Read data stand for exactly one cycle after the strobe.
      st_d.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            csc_pkg::OFF_KBD:   st_d.rdata = st_q.kbd;
            csc_pkg::OFF_CACHE: st_d.rdata = st_q.cache;
            csc_pkg::OFF_SEG:   st_d.rdata = st_q.seg;
            csc_pkg::OFF_STOP:  st_d.rdata = st_q.stop;
            default:            st_d.rdata = 8'h00;
         endcase
      end
      // Decoded outputs follow the stored fields with one cycle of latency.
      st_d.size     = size_code(st_q.cache[csc_pkg::CCH_SIZE_HI:csc_pkg::CCH_SIZE_LO]);
      rng           = range_decode(st_d.size, st_q.cache[csc_pkg::CCH_RANGE_HI:0]);
      st_d.limit    = rng.limit;
      st_d.single   = rng.single;
      st_d.all      = rng.all;
      st_d.valid    = rng.valid;
      st_d.page_off = st_q.cache[csc_pkg::CCH_PAGE_OFF] & st_q.cache[csc_pkg::CCH_WB];
      st_d.proc_en  = st_q.seg[csc_pkg::SEG_PROC] & st_q.seg[csc_pkg::SEG_QUAL];
      if (st_q.stop[csc_pkg::STP_FORCE] && st_q.stop[csc_pkg::STP_ALT]) begin
         st_d.turbo = 1'b0;
      end else begin
         st_d.turbo = speed_s ^ sw_speed_bit;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q       <= '0;
         st_q.kbd   <= csc_pkg::RST_KBD;
         st_q.cache <= csc_pkg::RST_CACHE;
         st_q.seg   <= csc_pkg::RST_SEG;
         st_q.stop  <= csc_pkg::RST_STOP;
      end else begin
         st_q <= st_d;
      end
   end

   assign sq.enable   = st_q.stop[csc_pkg::STP_EN];
   assign sq.skip     = st_q.stop[csc_pkg::STP_SKIP];
   assign sq.us_range = st_q.stop[csc_pkg::STP_US];
   assign sq.select   = st_q.stop[csc_pkg::STP_SEL_HI:csc_pkg::STP_SEL_LO];
   assign sq.grant    = grant_s;

   csc_stop_seq #(
      .MS0 (CYC_MS0),
      .MS1 (CYC_MS1),
      .MS2 (CYC_MS2)
   ) u_seq (
      .clk        (clk),
      .arst_n     (arst_n),
      .ctl        (sq.seq),
      .trigger    (halt_trigger),
      .halt_req_n (req_n)
   );

   // Plain flop views of stored bits.
   assign rdata            = st_q.rdata;
   assign kbd_enable       = st_q.kbd[csc_pkg::KBD_ENABLE];
   assign kbd_color_sel    = st_q.kbd[csc_pkg::KBD_COLOR];
   assign kbd_mouse_swap   = st_q.kbd[csc_pkg::KBD_SWAP];
   assign dirty_check_en   = st_q.kbd[csc_pkg::KBD_DIRTY];
   // Dirty status is never raised, so every line looks clean.
   assign dirty_status     = st_q.boot[2] & 1'b0;
   assign page_mode_off    = st_q.page_off;
   assign write_back_en    = st_q.cache[csc_pkg::CCH_WB];
   assign cache_size       = st_q.size;
   assign cache_limit      = st_q.limit;
   assign single_tag       = st_q.single;
   assign cache_all        = st_q.all;
   assign range_valid      = st_q.valid;
   assign seg_3000_en      = st_q.seg[csc_pkg::SEG_3000];
   assign seg_6000_en      = st_q.seg[csc_pkg::SEG_6000];
   assign seg_f000_en      = st_q.seg[csc_pkg::SEG_F000];
   assign mgmt_proc_en     = st_q.proc_en;
   assign dma_local_bus_en = st_q.seg[csc_pkg::SEG_DMA];
   assign alt_deturbo_en   = st_q.stop[csc_pkg::STP_ALT];
   assign turbo            = st_q.turbo;
   assign halt_busy        = sq.busy;
   assign clock_halt_request_n = req_n;
endmodule // csc_config_regs
`default_nettype wire

// *** csc_config_regs_properties.sv ***
// Checker for the configuration bank, bound to its top module.
// Assumes registers change only by wr at the mapped offsets.
`timescale 1ns/1ps
`default_nettype none
module csc_config_regs_properties (
   // Clock, reset and register port
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        wr,
   input wire logic [7:0]  addr,
   input wire logic [7:0]  wdata,
   // Halt handshake
   input wire logic        clock_halt_grant_n,
   input wire logic        clock_halt_request_n,
   // Observed outputs
   input wire logic        dirty_status,
   input wire logic        turbo,
   input wire logic        alt_deturbo_en,
   input wire logic        seg_3000_en,
   input wire logic        seg_6000_en,
   input wire logic        seg_f000_en,
   input wire logic        mgmt_proc_en,
   input wire logic        dma_local_bus_en,
   input wire logic        page_mode_off,
   input wire logic        write_back_en,
   input wire logic        cache_all,
   input wire logic        single_tag,
   input wire logic [2:0]  cache_size,
   input wire logic [25:0] cache_limit
);
   // Shadow copies let each output be tied to what was written.
   logic [7:0] cache_q, seg_q, stop_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {cache_q, seg_q, stop_q} <= '0;
      end else if (wr) begin
         if (addr == csc_pkg::OFF_CACHE) cache_q <= wdata;
         if (addr == csc_pkg::OFF_SEG) seg_q <= wdata;
         if (addr == csc_pkg::OFF_STOP) stop_q <= wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   seg_bits_a: assert property ({seg_3000_en, dma_local_bus_en, seg_f000_en, seg_6000_en} == {seg_q[5], seg_q[3:1]})
      else $error("segment enables differ");
   mgmt_qual_a: assert property (mgmt_proc_en == $past(seg_q[4] & seg_q[0]))
      else $error("management enable wrong");
   wb_mode_a: assert property (write_back_en == cache_q[3])
      else $error("write-back wrong");
   size_sel_a: assert property ({page_mode_off, cache_size} == $past({cache_q[7] & cache_q[3], cache_q[6] ? 3'h4 : {1'b0, cache_q[5:4]}}))
      else $error("size or page mode wrong");
   all_cache_a: assert property ((cache_q[6] && cache_q[2:0] == 3'h0) [*3] |-> cache_all && single_tag)
      else $error("all-cacheable missing");
   range_small_a: assert property ((cache_q[6:0] == 7'h01) [*3] |-> cache_limit == 26'h007FFFF)
      else $error("small range limit wrong");
   dirty_clean_a: assert property (!dirty_status)
      else $error("dirty status set");
   deturbo_bit_a: assert property (alt_deturbo_en == stop_q[2])
      else $error("de-turbo enable wrong");
   force_normal_a: assert property (stop_q[2:1] == 2'b11 |=> !turbo)
      else $error("turbo while forced normal");
   halt_off_a: assert property (!stop_q[0] |=> clock_halt_request_n)
      else $error("request while disabled");
   skip_fast_a: assert property (stop_q[5] && $fell(clock_halt_grant_n) |-> ##[1:8] clock_halt_request_n)
      else $error("request not released");
   hold_min_a: assert property (!stop_q[5] && $fell(clock_halt_grant_n) |-> !clock_halt_request_n [*8])
      else $error("request released early");
endmodule // csc_config_regs_properties
bind csc_config_regs csc_config_regs_properties csc_config_regs_properties_inst (.*);
`default_nettype wire

// *** csc_config_regs_test.sv ***
// Self-checking bench for the configuration bank and its halt handshake.
// Assumes short millisecond counts of 20, 40 and 80 cycles.
`timescale 1ns/1ps
`default_nettype none
module csc_config_regs_test;
   logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt_trigger = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic        speed_pin = 1'b0, sw_speed_bit = 1'b0, kbd_strap_a_n = 1'b1, kbd_strap_b_n = 1'b1;
   logic [3:0]  dly = 4'h1;
   logic [25:0] cache_limit;
   logic [2:0]  cache_size;
   logic        clock_halt_grant_n, clock_halt_request_n, kbd_enable, kbd_color_sel, kbd_mouse_swap;
   logic        dirty_check_en, dirty_status, page_mode_off, write_back_en, single_tag, cache_all;
   logic        range_valid, seg_3000_en, seg_6000_en, seg_f000_en, mgmt_proc_en, dma_local_bus_en;
   logic        alt_deturbo_en, turbo, halt_busy;
   int          n_mismatch = 0, n_checks = 0, cycles = 0;
   // Zero marks a range code with no defined limit.
   localparam logic [25:0] LIM [16] = '{26'h3FFFFF, 26'h7FFFF, 26'hFFFFFF, 26'h1FFFFFF,
      26'h7FFFFF, 26'hFFFFFF, 26'h1FFFFFF, 26'h3FFFFFF, 26'hFFFFFF, 26'h1FFFFFF, 26'h3FFFFFF, 26'h0,
      26'h1FFFFFF, 26'h3FFFFFF, 26'h0, 26'h0};
   csc_config_regs #(.CYC_MS0(20), .CYC_MS1(40), .CYC_MS2(80)) csc_config_regs_inst (.*);
   csc_cpu_model csc_cpu_model_inst (.*);
   always #2.5 clk = ~clk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         test_done;
      end
   end
   task automatic chk(input logic [25:0] got, input logic [25:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task automatic t_reset;
      int a;
      repeat (8) @(posedge clk);
      rchk(csc_pkg::OFF_KBD, 8'h80);
      for (a = 8'h1E; a < 8'h22; a++) rchk(8'(a), 8'h00);
      @(negedge clk);
      chk({rdata, clock_halt_request_n, dirty_status}, 10'h002);
      $display("t_reset done");
   endtask
   task automatic t_regs;
      wreg(csc_pkg::OFF_KBD, 8'hFF);
      rchk(csc_pkg::OFF_KBD, 8'hB1);
      chk({kbd_enable, kbd_color_sel, kbd_mouse_swap, dirty_check_en, dirty_status}, 5'h1E);
      wreg(csc_pkg::OFF_SEG, 8'hFE);
      rchk(csc_pkg::OFF_SEG, 8'h3E);
      chk({seg_3000_en, dma_local_bus_en, seg_f000_en, seg_6000_en, mgmt_proc_en}, 5'h1E);
      wreg(csc_pkg::OFF_SEG, 8'h11);
      rchk(csc_pkg::OFF_SEG, 8'h11);
      chk({seg_3000_en, dma_local_bus_en, seg_f000_en, seg_6000_en, mgmt_proc_en}, 5'h01);
      wreg(8'h21, 8'hFF);
      rchk(8'h21, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_cache;
      int s, j;
      for (s = 0; s < 4; s++) begin
         for (j = 0; j < 4; j++) begin
            wreg(csc_pkg::OFF_CACHE, {2'b00, s[1:0], 1'b0, 3'((1 << j) - 1)});
            repeat (3) @(negedge clk);
            chk({cache_size, cache_all, single_tag, range_valid}, {s[2:0], 1'b0, j == 0, LIM[s*4+j] != 0});
            chk(cache_limit, LIM[s*4+j]);
         end
      end
      wreg(csc_pkg::OFF_CACHE, 8'hD8);
      repeat (3) @(negedge clk);
      chk({page_mode_off, write_back_en, cache_size, cache_all, single_tag}, 7'h73);
      wreg(csc_pkg::OFF_CACHE, 8'hA0);
      repeat (3) @(negedge clk);
      chk({page_mode_off, write_back_en, cache_size}, 5'h02);
      $display("t_cache done");
   endtask
   task automatic t_speed;
      int i;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         speed_pin <= i[1];
         sw_speed_bit <= i[0];
         wreg(csc_pkg::OFF_STOP, {5'h00, i[3:2], 1'b0});
         repeat (8) @(negedge clk);
         chk({alt_deturbo_en, turbo}, {i[3], !(i[3] && i[2]) && (i[1] ^ i[0])});
      end
      $display("t_speed done");
   endtask
   task automatic pulse;
      @(posedge clk);
      halt_trigger <= 1'b1;
      @(posedge clk);
      halt_trigger <= 1'b0;
   endtask
   task automatic t_halt;
      int i, c;
      logic [7:0] m [7] = '{8'h01, 8'h41, 8'hC1, 8'h11, 8'h51, 8'h91, 8'h21};
      int lim [7] = '{20, 40, 80, 900, 1900, 3700, 0};
      pulse;
      repeat (10) @(negedge clk);
      chk({clock_halt_request_n, halt_busy}, 2'b10);
      for (i = 0; i < 7; i++) begin
         dly <= i[0] ? 4'h9 : 4'h1;
         wreg(csc_pkg::OFF_STOP, m[i]);
         pulse;
         for (c = 0; clock_halt_grant_n && c < 40; c++) @(negedge clk);
         for (c = 0; !clock_halt_request_n && c < 5000; c++) @(negedge clk);
         chk(c >= lim[i] && c <= lim[i] + 8, 1'b1);
         for (c = 0; halt_busy && c < 40; c++) @(negedge clk);
         chk(halt_busy, 1'b0);
      end
      $display("t_halt done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_regs;
      t_cache;
      t_speed;
      t_halt;
      test_done;
   end
endmodule // csc_config_regs_test
`default_nettype wire

// *** csc_cpu_model.sv ***
// Processor model on the far side of the halt handshake.
// Assumes the request is registered on clk; the grant lags by dly plus one cycles.
`timescale 1ns/1ps
`default_nettype none
module csc_cpu_model (
   // Clock and answer delay
   input  wire logic       clk,
   input  wire logic [3:0] dly,
   // Halt handshake
   input  wire logic       clock_halt_request_n,
   output logic            clock_halt_grant_n
);
   // A variable delay shows both prompt and slow answers.
   int unsigned wait_q = 0;
   initial clock_halt_grant_n = 1'b1;
   always @(posedge clk) begin
      wait_q <= clock_halt_request_n ? 0 : wait_q + 1;
      clock_halt_grant_n <= clock_halt_request_n | (wait_q < dly);
   end
endmodule // csc_cpu_model
`default_nettype wire

// *** csc_pkg.sv ***
// Package of offsets, field positions, reset values and timing constants for the configuration bank.
// Assumes a 200 MHz system clock and an 8-bit register port.
package csc_pkg;

   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Register offsets.
   localparam logic [7:0] OFF_KBD   = 8'h1D;
   localparam logic [7:0] OFF_CACHE = 8'h1E;
   localparam logic [7:0] OFF_SEG   = 8'h1F;
   localparam logic [7:0] OFF_STOP  = 8'h20;

   // Reset values.
   localparam logic [7:0] RST_KBD   = 8'h00;
   localparam logic [7:0] RST_CACHE = 8'h00;
   localparam logic [7:0] RST_SEG   = 8'h00;
   localparam logic [7:0] RST_STOP  = 8'h00;

   // Writable bit masks; other bits read as zero.
   localparam logic [7:0] MASK_KBD  = 8'hB1;
   localparam logic [7:0] MASK_SEG  = 8'h3F;

   // Keyboard and dirty control fields.
   localparam int unsigned KBD_ENABLE = 7;
   localparam int unsigned KBD_COLOR  = 5;
   localparam int unsigned KBD_SWAP   = 4;
   localparam int unsigned KBD_DIRTY  = 0;

   // Cache configuration fields.
   localparam int unsigned CCH_PAGE_OFF = 7;
   localparam int unsigned CCH_SIZE_HI  = 6;
   localparam int unsigned CCH_SIZE_LO  = 4;
   localparam int unsigned CCH_WB       = 3;
   localparam int unsigned CCH_RANGE_HI = 2;

   // Management segment fields.
   localparam int unsigned SEG_3000 = 5;
   localparam int unsigned SEG_PROC = 4;
   localparam int unsigned SEG_DMA  = 3;
   localparam int unsigned SEG_F000 = 2;
   localparam int unsigned SEG_6000 = 1;
   localparam int unsigned SEG_QUAL = 0;

   // Stop-clock and speed fields.
   localparam int unsigned STP_SEL_HI = 7;
   localparam int unsigned STP_SEL_LO = 6;
   localparam int unsigned STP_SKIP   = 5;
   localparam int unsigned STP_US     = 4;
   localparam int unsigned STP_ALT    = 2;
   localparam int unsigned STP_FORCE  = 1;
   localparam int unsigned STP_EN     = 0;

   // Cycles after reset release before the keyboard strap is taken.
   localparam logic [2:0] BOOT_CYCLES = 3'h5;

   // Recovery times, in picoseconds, and their cycle counts.
   localparam longint unsigned T_US0_PS = 64'd4500000;
   localparam longint unsigned T_US1_PS = 64'd9500000;
   localparam longint unsigned T_US2_PS = 64'd18500000;
   localparam longint unsigned T_MS0_PS = 64'd1000000000;
   localparam longint unsigned T_MS1_PS = 64'd2000000000;
   localparam longint unsigned T_MS2_PS = 64'd4000000000;
   localparam int unsigned CYC_US0 = int'(T_US0_PS / CLK_PERIOD_PS);
   localparam int unsigned CYC_US1 = int'(T_US1_PS / CLK_PERIOD_PS);
   localparam int unsigned CYC_US2 = int'(T_US2_PS / CLK_PERIOD_PS);
   localparam int unsigned CYC_MS0 = int'(T_MS0_PS / CLK_PERIOD_PS);
   localparam int unsigned CYC_MS1 = int'(T_MS1_PS / CLK_PERIOD_PS);
   localparam int unsigned CYC_MS2 = int'(T_MS2_PS / CLK_PERIOD_PS);
   localparam int unsigned CNT_W = 20;

   // Cache size codes.
   typedef enum logic [2:0] {
      CSC_SZ_32K  = 3'h0,
      CSC_SZ_64K  = 3'h1,
      CSC_SZ_128K = 3'h2,
      CSC_SZ_256K = 3'h3,
      CSC_SZ_512K = 3'h4
   } csc_size_t;

endpackage

// *** csc_seq_if.sv ***
// Interface between the register bank and the stop-clock sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface csc_seq_if;
   logic       enable;
   logic       skip;
   logic       us_range;
   logic [1:0] select;
   logic       grant;
   logic       busy;
   modport bank (output enable, output skip, output us_range, output select, output grant, input busy);
   modport seq  (input enable, input skip, input us_range, input select, input grant, output busy);
endinterface
`default_nettype wire

// *** csc_stop_seq.sv ***
// Stop-clock sequencer: raises the halt request, waits for the grant, holds for the recovery time.
// Assumes the grant arrives already synchronised, active high.
`timescale 1ns/1ps
`default_nettype none
module csc_stop_seq #(
   parameter int unsigned MS0 = csc_pkg::CYC_MS0,
   parameter int unsigned MS1 = csc_pkg::CYC_MS1,
   parameter int unsigned MS2 = csc_pkg::CYC_MS2
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Control from the bank
   csc_seq_if.seq    ctl,
   input  wire logic trigger,
   // Processor side
   output logic      halt_req_n
);
   typedef enum logic [1:0] {
      SQ_IDLE = 2'h0,
      SQ_REQ  = 2'h1,
      SQ_HOLD = 2'h3,
      SQ_DONE = 2'h2
   } csc_sq_t;

   typedef struct packed {
      csc_sq_t                      state;
      logic [csc_pkg::CNT_W-1:0]    cnt;
      logic                         req_n;
      logic                         busy;
   } csc_seq_t;

   csc_seq_t st_q, st_d;

   function automatic logic [csc_pkg::CNT_W-1:0] recovery(input logic us, input logic [1:0] sel);
      int unsigned n;
      if (us) begin
         n = sel[1] ? csc_pkg::CYC_US2 : (sel[0] ? csc_pkg::CYC_US1 : csc_pkg::CYC_US0);
      end else begin
         n = sel[1] ? MS2 : (sel[0] ? MS1 : MS0);
      end
      return csc_pkg::CNT_W'(n - 1);
   endfunction

   always_comb begin
      st_d = st_q;
      unique case (st_q.state)
         SQ_IDLE: begin
            if (trigger) begin
               st_d.state = SQ_REQ;
               st_d.req_n = 1'b0;
            end
         end
         SQ_REQ: begin
            if (ctl.grant) begin
               if (ctl.skip) begin
                  st_d.state = SQ_DONE;
                  st_d.req_n = 1'b1;
               end else begin
                  st_d.state = SQ_HOLD;
                  st_d.cnt   = recovery(ctl.us_range, ctl.select);
               end
            end
         end
         SQ_HOLD: begin
            if (st_q.cnt == '0) begin
               st_d.state = SQ_DONE;
               st_d.req_n = 1'b1;
            end else begin
               st_d.cnt = st_q.cnt - 1'b1;
            end
         end
         SQ_DONE: begin
            if (!ctl.grant) begin
               st_d.state = SQ_IDLE;
            end
         end
      endcase
      // Dropping the enable abandons any sequence in progress.
      if (!ctl.enable) begin
         st_d.state = SQ_IDLE;
         st_d.req_n = 1'b1;
         st_d.cnt   = '0;
      end
      // Busy is registered so the top output comes straight from a flop.
      st_d.busy = (st_d.state != SQ_IDLE);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '{state: SQ_IDLE, cnt: '0, req_n: 1'b1, busy: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign halt_req_n = st_q.req_n;
   assign ctl.busy   = st_q.busy;
endmodule // csc_stop_seq
`default_nettype wire

// *** csc_sync.sv ***
// Three-stage synchroniser for pins; the output follows once stages two and three agree.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module csc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Pins and filtered levels
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } csc_sync_t;

   csc_sync_t st_q, st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < int'(WIDTH); i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.out[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.out;
endmodule // csc_sync
`default_nettype wire
